/* File: rtl/qbs_params.svh */
// timing counts, tap weights and wavelet tables of the baseband shaper
`ifndef QBS_PARAMS_SVH
`define QBS_PARAMS_SVH
`define QBS_SPS        3'h6       // wavelet samples per symbol
`define QBS_PH_I       3'h0       // sample slot where the in-phase bit is taken
`define QBS_PH_Q       3'h3       // sample slot where the quadrature bit is taken
`define QBS_WAV_ONE    10'h100    // full scale amplitude, 1.0 in q1.8
`define QBS_TR0        10'h0f7    // cos ramp magnitude, samples 0 and 5
`define QBS_TR1        10'h0b5    // cos ramp magnitude, samples 1 and 4
`define QBS_TR2        10'h042    // cos ramp magnitude, samples 2 and 3
`define QBS_G0         10'h0bb    // cross term sqrt(1-a^2 cos^2), samples 0 and 5
`define QBS_G1         10'h0de    // cross term, samples 1 and 4
`define QBS_G2         10'h0fc    // cross term, samples 2 and 3
`define QBS_FB_INNER   18'h0000a  // second stage inner weight, 10/16
`define QBS_FB_OUTER   18'h00003  // second stage outer weight, magnitude 3/16
`define QBS_FIR_SHIFT  6          // 1/4 of first stage times 1/16 of second
`define QBS_CIC_N      4          // integrator-comb stage count
`define QBS_BUF_DEPTH  2'h2       // entries of the sample buffer
`endif

/* File: rtl/qbs_pkg.sv */
// types shared by the quadrature baseband shaper
`default_nettype none
package qbs_pkg;
  // one filtered sample pair, both channels in lockstep
  typedef struct packed {
    logic signed [11:0] i;
    logic signed [11:0] q;
  } qbs_iq_t;
endpackage
`default_nettype wire

/* File: rtl/qbs_shaper.sv */
// differential encoder, wavelet generator, shaping filter and cic interpolator
`timescale 1ns/1ps
`default_nettype none
`include "qbs_params.svh"
module qbs_shaper #(
  parameter int CIC_W = 28  // integrator width, must hold 12 bits plus cic gain
) (
  input  wire logic            mclk_i,       // 20 MHz sample clock
  input  wire logic            rstn_i,       // asynchronous reset, active low
  input  wire logic            ce_i,         // clock enable, freezes all state while low
  input  wire logic            bit_i,        // randomized nrz-l data bit
  input  wire logic            bit_valid_i,  // bit_i holds a bit
  output logic                 bit_ready_o,  // shaper can take a bit this cycle, taken when bit_valid_i is high
  input  wire logic [1:0]      rate_sel_i,   // interpolation ratio 2 << rate_sel_i
  output qbs_pkg::qbs_iq_t     sample_o,     // interpolated i/q pair to the d/a pair
  output logic                 sample_valid_o, // sample_o holds a new pair
  input  wire logic            sample_ready_i  // d/a side accepts sample_o
);
  // integrator width must cover 12 input bits plus the largest cic gain
  if (CIC_W < 26 || CIC_W > 40) begin : g_bad_width
    $error("CIC_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // front end: sample slot, encoder and wavelets
  logic [2:0]  s;                 // sample slot in the in-phase symbol, 0..5
  logic        i_cur, i_prev;     // current and previous in-phase symbol
  logic        q_cur, q_prev;     // current and previous quadrature symbol
  logic        next_i_cur, next_q_cur;
  logic        next_i_prev, next_q_prev; // symbol pair spanned by this slot's wavelet
  logic        take_slot;         // a bit is due in this slot
  logic        buf_full;          // sample buffer cannot take a pair
  logic        adv;               // front end moves one sample
  logic [2:0]  q_ph;              // slot inside the quadrature symbol

  assign take_slot   = (s == `QBS_PH_I) || (s == `QBS_PH_Q);
  // back-pressure from the buffer stalls the bit intake as well
  assign bit_ready_o = ce_i && !buf_full && take_slot;
  assign adv         = ce_i && !buf_full && (!take_slot || bit_valid_i);
  assign q_ph        = (s >= `QBS_PH_Q) ? s - `QBS_PH_Q : s + `QBS_PH_Q;

  // encoder: always applied, there is no bypass mode
  always_comb begin
    next_i_cur = i_cur;
    next_q_cur = q_cur;
    // at a boundary slot the stored symbol becomes the old one, so the first
    // sample of a transition already sees the right pair
    next_i_prev = (s == `QBS_PH_I) ? i_cur : i_prev;
    next_q_prev = (s == `QBS_PH_Q) ? q_cur : q_prev;
    if (s == `QBS_PH_I) next_i_cur = bit_i ^ ~q_cur;
    if (s == `QBS_PH_Q) next_q_cur = bit_i ^ i_cur;
  end

  // slot counter, six samples per symbol
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= 3'h0;
    end else if (adv) begin
      s <= (s == `QBS_SPS - 3'h1) ? 3'h0 : s + 3'h1;
    end
  end

  // symbol history; the quadrature update sits three slots later
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      i_cur  <= 1'b0;
      i_prev <= 1'b0;
      q_cur  <= 1'b0;
      q_prev <= 1'b0;
    end else if (adv) begin
      if (s == `QBS_PH_I) begin
        i_prev <= i_cur;
        i_cur  <= next_i_cur;
      end
      if (s == `QBS_PH_Q) begin
        q_prev <= q_cur;
        q_cur  <= next_q_cur;
      end
    end
  end

  // wavelet sample: own transition ramps between signs, a steady symbol is
  // scaled down while the other channel is in transition (cross term)
  function automatic logic signed [9:0] wav(input logic prv, input logic cur,
                                            input logic [2:0] ph, input logic oprv,
                                            input logic ocur, input logic [2:0] oph);
    logic [9:0] mag;
    logic [2:0] k;
    mag = `QBS_WAV_ONE;
    k   = (ph > 3'h2) ? 3'h5 - ph : ph;
    if (prv != cur) begin
      // ramp magnitude, old sign for the first half, new sign for the second
      mag = (k == 3'h0) ? `QBS_TR0 : (k == 3'h1) ? `QBS_TR1 : `QBS_TR2;
      return ((ph < 3'h3) ^ cur) ? $signed(mag) : -$signed(mag);
    end
    if (oprv != ocur) begin
      k   = (oph > 3'h2) ? 3'h5 - oph : oph;
      mag = (k == 3'h0) ? `QBS_G0 : (k == 3'h1) ? `QBS_G1 : `QBS_G2;
    end
    return cur ? $signed(mag) : -$signed(mag);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // shaping filter, one lane per channel
  logic signed [9:0]  wv   [2][3];  // wavelet history per channel
  logic signed [11:0] sa   [2][3];  // first stage outputs, delayed
  logic signed [11:0] sa_n [2];     // first stage output now
  logic signed [17:0] acc  [2];     // second stage sum, scaled by 64
  logic signed [11:0] fir  [2];     // filtered sample

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_lane
      // first stage: three equal quarter weights, scale kept for later
      assign sa_n[ch] = 12'(wv[ch][0]) + 12'(wv[ch][1]) + 12'(wv[ch][2]);
      // second stage: -3/16, 10/16, 10/16, -3/16; combined taps mirror
      assign acc[ch] = (18'(sa[ch][0]) + 18'(sa[ch][1])) * $signed(`QBS_FB_INNER)
                     - (18'(sa_n[ch]) + 18'(sa[ch][2])) * $signed(`QBS_FB_OUTER);
      assign fir[ch] = acc[ch][`QBS_FIR_SHIFT +: 12];

      // both lanes shift on the same advance, keeping i and q aligned
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          wv[ch] <= '{default: 10'h000};
          sa[ch] <= '{default: 12'h000};
        end else if (adv) begin
          wv[ch][2] <= wv[ch][1];
          wv[ch][1] <= wv[ch][0];
          wv[ch][0] <= (ch == 0) ? wav(next_i_prev, next_i_cur, s, next_q_prev, next_q_cur, q_ph)
                                 : wav(next_q_prev, next_q_cur, q_ph, next_i_prev, next_i_cur, s);
          sa[ch][2] <= sa[ch][1];
          sa[ch][1] <= sa[ch][0];
          sa[ch][0] <= sa_n[ch];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // two-entry buffer between filter and interpolator
  qbs_pkg::qbs_iq_t buf_mem [2];   // stored pairs
  logic             wp, rp;        // write and read pointers
  logic [1:0]       cnt;           // occupancy
  logic             pop;           // interpolator takes a pair
  logic             buf_valid;     // a pair waits

  assign buf_full  = (cnt == `QBS_BUF_DEPTH);
  assign buf_valid = (cnt != 2'h0);

  // pointers and count; push and pop may meet in one cycle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (adv) wp <= ~wp;
      if (pop) rp <= ~rp;
      cnt <= cnt + {1'b0, adv} - {1'b0, pop};
    end
  end

  // storage; holds no control state so it needs no reset
  always_ff @(posedge mclk_i) begin
    if (adv) buf_mem[wp] <= '{i: fir[0], q: fir[1]};
  end

  ////////////////////////////////////////////////////////////////////////
  // cic interpolator: combs at input rate, integrators at output rate
  logic [4:0]              ratio;      // interpolation ratio
  logic [3:0]              shift;      // gain removal, 3 * log2(ratio)
  logic [4:0]              ph;         // output phase inside one input sample
  logic                    step;       // one output sample produced
  logic signed [CIC_W-1:0] cx  [2][`QBS_CIC_N+1];
  logic signed [CIC_W-1:0] cd  [2][`QBS_CIC_N];
  logic signed [CIC_W-1:0] itg [2][`QBS_CIC_N];
  logic signed [CIC_W-1:0] shv [2];

  assign ratio = 5'h02 << rate_sel_i;
  assign shift = 4'h3 * ({2'h0, rate_sel_i} + 4'h1);
  assign step  = ce_i && (!sample_valid_o || sample_ready_i) && (ph != 5'h00 || buf_valid);
  assign pop   = step && (ph == 5'h00);

  // output phase counter
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph <= 5'h00;
    end else if (step) begin
      ph <= (ph >= ratio - 5'h01) ? 5'h00 : ph + 5'h01;
    end
  end

  genvar c, k;
  generate
    for (c = 0; c < 2; c++) begin : g_cic
      assign cx[c][0] = (c == 0) ? CIC_W'(buf_mem[rp].i) : CIC_W'(buf_mem[rp].q);
      for (k = 0; k < `QBS_CIC_N; k++) begin : g_stage
        assign cx[c][k+1] = cx[c][k] - cd[c][k];
        // comb delay of one input sample, integrators on every output
        always_ff @(posedge mclk_i or negedge rstn_i) begin
          if (!rstn_i) begin
            cd[c][k]  <= '0;
            itg[c][k] <= '0;
          end else if (step) begin
            if (pop) cd[c][k] <= cx[c][k];
            if (k == 0) itg[c][k] <= itg[c][k] + (pop ? cx[c][`QBS_CIC_N] : '0);
            else        itg[c][k] <= itg[c][k] + itg[c][k > 0 ? k-1 : 0];
          end
        end
      end
      assign shv[c] = itg[c][`QBS_CIC_N-1] >>> shift;
    end
  endgenerate

  // registered output pair; holds while the d/a side stalls
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sample_o       <= '0;
      sample_valid_o <= 1'b0;
    end else if (ce_i) begin
      if (step) begin
        sample_o       <= '{i: shv[0][11:0], q: shv[1][11:0]};
        sample_valid_o <= 1'b1;
      end else if (sample_ready_i) begin
        sample_valid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  bit_slot_a: assert property (bit_ready_o |-> (s == 3'h0 || s == 3'h3))
    else $error("bit taken outside its slot");
  i_encode_a: assert property (adv && s == 3'h0 |=> i_cur == ($past(bit_i) ^ ~$past(q_cur)))
    else $error("in-phase symbol encoded wrongly");
  q_encode_a: assert property (adv && s == 3'h3 |=> q_cur == ($past(bit_i) ^ $past(i_cur)))
    else $error("quadrature symbol encoded wrongly");
  q_offset_a: assert property ($changed(q_cur) |-> $past(s) == 3'h3)
    else $error("quadrature boundary not one bit late");
  i_hold_a: assert property ($changed(i_cur) |-> $past(s) == 3'h0)
    else $error("in-phase symbol changed mid symbol");
  six_slot_a: assert property (adv && s == 3'h5 |=> s == 3'h0)
    else $error("symbol not six samples long");
  steady_wav_a: assert property (adv && s == 3'h1 && i_prev == i_cur && q_prev == q_cur
                                 |=> wv[0][0] == (i_cur ? 10'sh100 : -10'sh100))
    else $error("steady wavelet not full scale");
  cic_phase_a: assert property (ph < ratio)
    else $error("interpolator phase beyond ratio");
  out_hold_a: assert property (sample_valid_o && !sample_ready_i |=> $stable(sample_o) && sample_valid_o)
    else $error("output changed under stall");
endmodule
`default_nettype wire

/* File: testbench/qbs_dac_model.sv */
// d/a pair model that takes shaped i/q pairs and can stall on command
`timescale 1ns/1ps
`default_nettype none
module qbs_dac_model (
  input  wire logic             mclk_i,         // sample clock
  input  wire logic             rstn_i,         // asynchronous reset, active low
  input  wire qbs_pkg::qbs_iq_t sample_i,       // pair offered by the shaper
  input  wire logic             sample_valid_i, // pair is offered
  input  wire logic             stall_i,        // bench asks the converters to hold off
  output logic                  sample_ready_o, // converters accept the pair
  output var int                taken_o,        // pairs taken since reset
  output qbs_pkg::qbs_iq_t      last_o          // last pair taken
);
  ////////////////////////////////////////////////////////////////////////////
  // ready moves just after an edge, like a real converter front end
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sample_ready_o <= 1'b0;
    end else begin
      sample_ready_o <= ~stall_i;
    end
  end
  // both halves latched on one edge, so a torn pair cannot hide
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      taken_o <= 0;
      last_o  <= '0;
    end else if (sample_valid_i && sample_ready_o) begin
      taken_o <= taken_o + 1;
      last_o  <= sample_i;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_quadrature_baseband_shaper.sv */
// self-checking bench for the quadrature baseband shaper
`timescale 1ns/1ps
`default_nettype none
module test_quadrature_baseband_shaper;
  logic             mclk_i = 1'b0;      // 20 MHz sample clock
  logic             rstn_i = 1'b0;      // reset, active low
  logic             ce_i = 1'b1;        // clock enable
  logic             bit_i = 1'b0;       // data bit to the encoder
  logic             bit_valid_i = 1'b0; // bench offers a bit
  logic             bit_ready_o;        // shaper takes the bit
  logic [1:0]       rate_sel_i = 2'h0;  // interpolation ratio select
  qbs_pkg::qbs_iq_t sample_o;           // shaped pair
  logic             sample_valid_o;     // pair offered
  logic             sample_ready_i;     // model accepts
  logic             stall = 1'b0;       // hold the model off
  int               taken;              // pairs taken by the model
  qbs_pkg::qbs_iq_t last;               // last pair taken
  int               miscompares = 0;    // mismatches
  int               cmp_count = 0;      // comparisons made
  int               cyc = 0;            // cycle counter
  int               tk;                 // cycle of the last bit taken
  logic             prev_i, prev_q, odd; // reference encoder state
  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc++;
  qbs_shaper dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .bit_i(bit_i), .bit_valid_i(bit_valid_i),
    .bit_ready_o(bit_ready_o), .rate_sel_i(rate_sel_i), .sample_o(sample_o),
    .sample_valid_o(sample_valid_o), .sample_ready_i(sample_ready_i));
  qbs_dac_model dac (.mclk_i(mclk_i), .rstn_i(rstn_i), .sample_i(sample_o), .sample_valid_i(sample_valid_o),
    .stall_i(stall), .sample_ready_o(sample_ready_i), .taken_o(taken), .last_o(last));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // reset with a ratio; rate select may only move under reset
  task automatic do_reset(input logic [1:0] sel);
    rstn_i = 1'b0;
    rate_sel_i = sel;
    bit_valid_i = 1'b0;
    repeat (10) @(negedge mclk_i);
    chk("ready in reset", 32'(ce_i), 32'(bit_ready_o));
    chk("valid in reset", 32'h0, 32'(sample_valid_o));
    chk("sample in reset", 32'h0, 32'(sample_o));
    rstn_i = 1'b1;
    {prev_i, prev_q, odd} = 3'h0;
  endtask
  // offer one randomized-looking bit and hold it until taken
  task automatic send(input logic b);
    int n;
    bit_i = b;
    bit_valid_i = 1'b1;
    for (n = 0; n < 800 && bit_ready_o !== 1'b1; n++) @(negedge mclk_i);
    chk("bit taken", 32'h1, 32'(bit_ready_o));
    tk = cyc;
    @(negedge mclk_i);
  endtask
  // pick the bit that gives a wanted symbol; even bits feed i, odd bits q
  task automatic send_sym(input logic t);
    if (odd) begin
      send(t ^ prev_i);
      prev_q = t;
    end else begin
      send(t ^ ~prev_q);
      prev_i = t;
    end
    odd = ~odd;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // steady symbols in each quadrant give the mapped output signs
  task automatic t_quadrants();
    logic [1:0] iq [4] = '{2'b11, 2'b01, 2'b00, 2'b10};
    do_reset(2'h0);
    foreach (iq[k]) begin
      repeat (30) begin
        send_sym(iq[k][1]);
        send_sym(iq[k][0]);
      end
      chk("i sign", 32'(!iq[k][1]), 32'(last.i[11]));
      chk("q sign", 32'(!iq[k][0]), 32'(last.q[11]));
      chk("i nonzero", 32'h1, 32'(last.i != 12'h000));
    end
    bit_valid_i = 1'b0;
  endtask
  // ratio per select, six samples per symbol, q a half symbol behind i
  task automatic t_rate();
    int c0, t0, t1;
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      repeat (4) send_sym(1'b1);
      c0 = taken;
      t0 = tk;
      send_sym(1'b0);
      t1 = tk;
      send_sym(1'b1);
      chk("half symbol gap", 32'(t1 - t0), 32'(tk - t1));
      chk("bit spacing", 32'(3 * (2 << s)), 32'(t1 - t0));
      repeat (8) send_sym(1'b0);
      chk("pairs per 10 bits", 32'(30 * (2 << s)), 32'(taken - c0));
      bit_valid_i = 1'b0;
    end
  endtask
  // converter stall fills the buffer, pair holds, front end stops
  task automatic t_stall();
    qbs_pkg::qbs_iq_t held;
    int c0;
    do_reset(2'h0);
    // slot 0 with an empty buffer: only the enable keeps ready low
    ce_i = 1'b0;
    @(negedge mclk_i);
    chk("ready with ce low at slot", 32'h0, 32'(bit_ready_o));
    ce_i = 1'b1;
    repeat (6) send_sym(1'b1);
    // withdraw the bit so no stale value is taken while stalled
    bit_valid_i = 1'b0;
    stall = 1'b1;
    repeat (100) @(negedge mclk_i);
    held = sample_o;
    chk("valid in stall", 32'h1, 32'(sample_valid_o));
    repeat (20) @(negedge mclk_i);
    chk("pair held", 32'(held), 32'(sample_o));
    chk("front end stalled", 32'h0, 32'(bit_ready_o));
    ce_i = 1'b0;
    @(negedge mclk_i);
    chk("ready with ce low", 32'h0, 32'(bit_ready_o));
    ce_i = 1'b1;
    stall = 1'b0;
    c0 = taken;
    repeat (4) send_sym(1'b1);
    chk("resumed", 32'h1, 32'(taken - c0 > 12));
    bit_valid_i = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    @(negedge mclk_i);
    t_quadrants();
    t_rate();
    t_stall();
    results();
  end
  // the whole run needs well under 40000 cycles
  initial begin
    repeat (40000) @(posedge mclk_i);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
